/* File: timer_pkg.sv */
// constants and carrier types for the split auto-reload timer
package timer_pkg;

  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hcd;

  localparam int BIT_HIGH_FLAG  = 7;
  localparam int BIT_LOW_FLAG   = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_ALT_SEL    = 0;

  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic [7:0] CONTROL_WMASK  = 8'hed;
  localparam logic [7:0] BYTE_ALL_ONES  = 8'hff;

  localparam int SYS_DIV     = 12;
  localparam int EXT_DIV     = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic high_byte_clock_select;
    logic low_byte_clock_select;
  } clock_sel_t;

endpackage

/* File: ext_tick_sync.sv */
// external oscillator divide-by-8 with tick brought into the system clock
`timescale 1ns/10ps
module ext_tick_sync
  import timer_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic ext_osc,
  output logic      ext_tick
);

  logic [2:0] osc_sync_r;
  logic [2:0] div_r;

  // two flops then an edge detector on the second and third stages
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_sync_r <= 3'h0;
    end else if (ce) begin
      osc_sync_r <= {osc_sync_r[1:0], ext_osc};
    end
  end

  // counts rising edges of the oscillator; emits one tick every eighth
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r    <= 3'h0;
      ext_tick <= 1'b0;
    end else if (ce) begin
      ext_tick <= 1'b0;
      if (osc_sync_r[1] && !osc_sync_r[2]) begin
        if (div_r == EXT_DIV_LAST) begin
          div_r    <= 3'h0;
          ext_tick <= 1'b1;
        end else begin
          div_r <= div_r + 3'h1;
        end
      end
    end
  end

endmodule

/* File: auto_reload_timer_split.sv */
// 16-bit auto-reload timer, splittable into two 8-bit auto-reload timers
`timescale 1ns/10ps
module auto_reload_timer_split
  import timer_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  timer_pkg::sfr_req_t   sfr_req,
  input  timer_pkg::clock_sel_t clock_sel,
  input  wire logic       timer_interrupt_enable,
  input  wire logic       ext_osc,
  output logic [7:0]      sfr_rdata,
  output logic            irq
);

  logic [7:0] control_r;
  logic [7:0] reload_low_r;
  logic [7:0] reload_high_r;
  logic [7:0] count_low_r;
  logic [7:0] count_high_r;
  logic [3:0] presc_r;
  logic       presc_tick_r;
  logic       ext_tick;
  logic       alt_tick;
  logic       low_tick;
  logic       high_tick;
  logic       low_src;
  logic       high_src;
  logic       low_wrap;
  logic       high_wrap;
  logic       split_mode;
  logic       run_control;
  logic       low_byte_irq_enable;
  logic       high_overflow_flag;
  logic       low_overflow_flag;

  // one-hot address decode used by read mux and all write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  function automatic logic writes(input sfr_req_t r, input logic [7:0] target);
    writes = r.wr && hit(r.addr, target);
  endfunction

  assign split_mode          = control_r[BIT_SPLIT];
  assign run_control         = control_r[BIT_RUN];
  assign low_byte_irq_enable = control_r[BIT_LOW_IRQ_EN];
  assign high_overflow_flag  = control_r[BIT_HIGH_FLAG];
  assign low_overflow_flag   = control_r[BIT_LOW_FLAG];

  ext_tick_sync u_ext_tick_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ce       (ce),
    .ext_osc  (ext_osc),
    .ext_tick (ext_tick)
  );

  // free-running divide-by-12 of the system clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      presc_r      <= 4'h0;
      presc_tick_r <= 1'b0;
    end else if (ce) begin
      presc_tick_r <= (presc_r == SYS_DIV_LAST);
      if (presc_r == SYS_DIV_LAST) begin
        presc_r <= 4'h0;
      end else begin
        presc_r <= presc_r + 4'h1;
      end
    end
  end

  assign alt_tick = control_r[BIT_ALT_SEL] ? ext_tick : presc_tick_r;

  assign low_src  = clock_sel.low_byte_clock_select ? 1'b1 : alt_tick;
  assign high_src = clock_sel.high_byte_clock_select ? 1'b1 : alt_tick;

  // low select drives the whole timer in 16-bit mode; high select only when split
  always_comb begin
    if (split_mode) begin
      low_tick  = low_src;
      high_tick = high_src && run_control;
    end else begin
      low_tick  = low_src && run_control;
      high_tick = low_src && run_control;
    end
  end

  // in 16-bit mode the upper byte only steps on the lower byte's carry
  assign low_wrap  = low_tick && (count_low_r == BYTE_ALL_ONES);
  assign high_wrap = split_mode ? (high_tick && (count_high_r == BYTE_ALL_ONES))
                                : (low_wrap && (count_high_r == BYTE_ALL_ONES));

  // lower counter byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_low_r <= BYTE_RESET;
    end else if (ce) begin
      if (writes(sfr_req, ADDR_COUNT_LOW)) begin
        count_low_r <= sfr_req.wdata;
      end else if (split_mode && low_wrap) begin
        count_low_r <= reload_low_r;
      end else if (!split_mode && high_wrap) begin
        count_low_r <= reload_low_r;
      end else if (low_tick) begin
        count_low_r <= count_low_r + 8'h01;
      end
    end
  end

  // upper counter byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_high_r <= BYTE_RESET;
    end else if (ce) begin
      if (writes(sfr_req, ADDR_COUNT_HIGH)) begin
        count_high_r <= sfr_req.wdata;
      end else if (high_wrap) begin
        count_high_r <= reload_high_r;
      end else if (split_mode ? high_tick : low_wrap) begin
        count_high_r <= count_high_r + 8'h01;
      end
    end
  end

  // reload bytes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reload_low_r  <= BYTE_RESET;
      reload_high_r <= BYTE_RESET;
    end else if (ce) begin
      if (writes(sfr_req, ADDR_RELOAD_LOW)) begin
        reload_low_r <= sfr_req.wdata;
      end
      if (writes(sfr_req, ADDR_RELOAD_HIGH)) begin
        reload_high_r <= sfr_req.wdata;
      end
    end
  end

  // control; a wrap in the same cycle as a software clear keeps the flag set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_r <= CONTROL_RESET;
    end else if (ce) begin
      if (writes(sfr_req, ADDR_TIMER_CONTROL)) begin
        control_r <= sfr_req.wdata & CONTROL_WMASK;
      end
      if (high_wrap) begin
        control_r[BIT_HIGH_FLAG] <= 1'b1;
      end
      if (low_wrap) begin
        control_r[BIT_LOW_FLAG] <= 1'b1;
      end
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce) begin
      if (!sfr_req.rd) begin
        sfr_rdata <= 8'h00;
      end else if (hit(sfr_req.addr, ADDR_TIMER_CONTROL)) begin
        sfr_rdata <= control_r & CONTROL_WMASK;
      end else if (hit(sfr_req.addr, ADDR_RELOAD_LOW)) begin
        sfr_rdata <= reload_low_r;
      end else if (hit(sfr_req.addr, ADDR_RELOAD_HIGH)) begin
        sfr_rdata <= reload_high_r;
      end else if (hit(sfr_req.addr, ADDR_COUNT_LOW)) begin
        sfr_rdata <= count_low_r;
      end else if (hit(sfr_req.addr, ADDR_COUNT_HIGH)) begin
        sfr_rdata <= count_high_r;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // level request, gated by timer_interrupt_enable, follows the high flag, and the low flag only when its enable bit is set; one cycle behind them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= timer_interrupt_enable &&
             (high_overflow_flag || (low_overflow_flag && low_byte_irq_enable));
    end
  end

endmodule

/* File: auto_reload_timer_split_asserts.sv */
// port assertions for the split auto-reload timer
`timescale 1ns/10ps
module timer_split_checker
  import timer_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst,
  input wire logic           ce,
  input timer_pkg::sfr_req_t sfr_req,
  input wire logic           timer_interrupt_enable,
  input wire logic [7:0]     sfr_rdata,
  input wire logic           irq
);
  import timer_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    ce && sfr_req.wr && sfr_req.addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    ce && sfr_req.rd && !sfr_req.wr && sfr_req.addr == a;
  endsequence
  sequence s_quiet;
    ce && timer_interrupt_enable && !sfr_req.wr;
  endsequence
  // flags may be set by hardware meanwhile, so m hides them
  property p_wr_rd(logic [7:0] a, logic [7:0] m, logic [7:0] w);
    s_wr(a) ##1 (ce && !sfr_req.wr) ##1 s_rd(a) |=>
      (sfr_rdata & m) == ($past(sfr_req.wdata, 3) & w);
  endproperty
  a_rl_low_rw: assert property (p_wr_rd(ADDR_RELOAD_LOW, 8'hff, 8'hff))
    else $error("reload low readback wrong");
  a_rl_high_rw: assert property (p_wr_rd(ADDR_RELOAD_HIGH, 8'hff, 8'hff))
    else $error("reload high readback wrong");
  a_ctrl_rw: assert property (p_wr_rd(ADDR_TIMER_CONTROL, 8'h3f, 8'h2d))
    else $error("control readback wrong");
  a_rdata_idle: assert property (ce && !sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (ce && sfr_req.rd && !(sfr_req.addr inside
    {8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd}) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clear: assert property (disable iff (1'b0) rst && ce |=> !irq && sfr_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  a_irq_gate: assert property (ce && !timer_interrupt_enable |=> !irq)
    else $error("request without enable");
  a_irq_hold: assert property (s_quiet[*2] ##0 irq ##1 s_quiet |=> irq)
    else $error("request dropped without software clear");
endmodule
bind auto_reload_timer_split timer_split_checker u_chk (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .sfr_req(sfr_req), .timer_interrupt_enable(timer_interrupt_enable),
  .sfr_rdata(sfr_rdata), .irq(irq));

/* File: sfr_master.sv */
// processor core model driving the register bus
`timescale 1ns/10ps
module sfr_master
  import timer_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic [7:0]     sfr_rdata,
  output timer_pkg::sfr_req_t sfr_req
);
  import timer_pkg::*;
  initial sfr_req = '0;
  // an idle cycle after each access keeps strobes one cycle wide
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    sfr_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(negedge sys_clk);
    sfr_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    sfr_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    sfr_req = '0;
    v = sfr_rdata;
  endtask
endmodule

/* File: auto_reload_timer_split_tb.sv */
// self-checking bench for the split auto-reload timer
`timescale 1ns/10ps
module auto_reload_timer_split_tb;
  import timer_pkg::*;
  localparam logic [7:0] MAP [6] = '{ADDR_TIMER_CONTROL, ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH,
                                     ADDR_COUNT_LOW, ADDR_COUNT_HIGH, 8'hc9};
  localparam logic [7:0] STEP [3] = '{8'h04, 8'h02, 8'h30};
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext_osc = 1'b0;
  logic       ien = 1'b0;
  clock_sel_t csel = '0;
  sfr_req_t   req;
  logic [7:0] rdata, d, d0;
  logic       irq;
  int         error_cnt = 0;
  int         comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  // oscillator edges kept clear of system clock edges
  initial begin
    #37;
    forever #150 ext_osc = ~ext_osc;
  end
  sfr_master cpu (.sys_clk(sys_clk), .sfr_rdata(rdata), .sfr_req(req));
  auto_reload_timer_split uut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .sfr_req(req),
    .clock_sel(csel), .timer_interrupt_enable(ien), .ext_osc(ext_osc), .sfr_rdata(rdata),
    .irq(irq));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    cpu.rd(a, d);
    check(what, d, exp);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) rchk(MAP[i], 8'h00, "reset value");
    cpu.wr(ADDR_RELOAD_LOW, 8'h5a);
    rchk(ADDR_RELOAD_LOW, 8'h5a, "reload low");
    cpu.wr(ADDR_RELOAD_HIGH, 8'ha5);
    rchk(ADDR_RELOAD_HIGH, 8'ha5, "reload high");
    cpu.wr(ADDR_TIMER_CONTROL, 8'h3f);
    rchk(ADDR_TIMER_CONTROL, 8'h2d, "control");
    cpu.wr(ADDR_TIMER_CONTROL, 8'h00);
    $display("register test done");
    csel.low_byte_clock_select = 1'b1;
    ien = 1'b1;
    cpu.wr(ADDR_COUNT_LOW, 8'hfe);
    cpu.wr(ADDR_COUNT_HIGH, 8'hff);
    cpu.wr(ADDR_TIMER_CONTROL, 8'h04);
    repeat (4) @(negedge sys_clk);
    rchk(ADDR_TIMER_CONTROL, 8'hc4, "wide wrap flags");
    check("irq wide", {7'h00, irq}, 8'h01);
    rchk(ADDR_COUNT_HIGH, 8'ha5, "wide reload");
    cpu.wr(ADDR_TIMER_CONTROL, 8'h00);
    repeat (2) @(negedge sys_clk);
    check("irq cleared", {7'h00, irq}, 8'h00);
    $display("wide test done");
    cpu.wr(ADDR_COUNT_LOW, 8'hff);
    cpu.wr(ADDR_TIMER_CONTROL, 8'h08);
    rchk(ADDR_COUNT_LOW, 8'h5a, "split low reload");
    rchk(ADDR_TIMER_CONTROL, 8'h48, "split low flag");
    check("irq low masked", {7'h00, irq}, 8'h00);
    cpu.wr(ADDR_TIMER_CONTROL, 8'h68);
    repeat (2) @(negedge sys_clk);
    check("irq low shared", {7'h00, irq}, 8'h01);
    rchk(ADDR_COUNT_HIGH, 8'ha5, "high stopped");
    $display("split test done");
    for (int i = 0; i < 3; i++) begin
      csel.high_byte_clock_select = (i == 2);
      cpu.wr(ADDR_TIMER_CONTROL, (i == 1) ? 8'h0d : 8'h0c);
      cpu.wr(ADDR_COUNT_HIGH, 8'h00);
      cpu.rd(ADDR_COUNT_HIGH, d0);
      repeat (46) @(negedge sys_clk);
      cpu.rd(ADDR_COUNT_HIGH, d);
      check("high ticks", d - d0, STEP[i]);
    end
    cpu.wr(ADDR_COUNT_HIGH, 8'hff);
    rchk(ADDR_COUNT_HIGH, 8'ha5, "split high reload");
    cpu.rd(ADDR_TIMER_CONTROL, d);
    check("split high flag", d & 8'h80, 8'h80);
    check("irq split high", {7'h00, irq}, 8'h01);
    $display("timebase test done");
    report_and_stop;
  end
endmodule
